/* logic/system_address_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sys_decode_regs.svh"

module system_address_decoder (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     req_valid,
  input  wire logic [31:0]              req_addr,
  input  wire logic                     req_write,
  input  wire logic                     tgt_done,
  input  wire logic                     tgt_error,
  output logic [`TARGET_COUNT-1:0]      tgt_sel,
  output logic [31:0]                   tgt_offset,
  output logic                          tgt_write,
  output logic                          xfer_done,
  output logic                          xfer_abort,
  output logic                          xfer_raz
);

  localparam int N = `TARGET_COUNT;

  typedef struct packed {
    sys_decode_pkg::state_t st;
    logic [N-1:0]           sel;
    logic [31:0]            offset;
    logic                   write;
    logic                   done;
    logic                   abort;
    logic                   raz;
  } dec_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame table

  localparam logic [31:0] BASE [N] = '{
    `FLASH_BASE, `DCACHE_BASE, `ICACHE_BASE, `CS2_BASE, `CS3_BASE, `CS4_BASE,
    `CS0_BASE, `FECC_BASE, `ETH_SLV_BASE, `ETH_DESC_BASE, `CRC1_BASE, `CRC2_BASE,
    `SB5_BASE, `SB4_BASE, `SB3_BASE, `SB2_BASE, `SB1_BASE,
    `CAN4_BASE, `CAN3_BASE, `CAN2_BASE, `CAN1_BASE,
    `CONV2_BASE, `CONV1_BASE, `TMR2_BASE, `TMR1_BASE, `DBG_BASE};

  localparam logic [31:0] SPAN [N] = '{
    `SPAN_4M, `SPAN_16M, `SPAN_16M, `SPAN_64M, `SPAN_64M, `SPAN_64M,
    `SPAN_128M, `SPAN_2M, `SPAN_2K, `SPAN_8K, `SPAN_16M, `SPAN_16M,
    `SPAN_128K, `SPAN_128K, `SPAN_128K, `SPAN_128K, `SPAN_128K,
    `SPAN_128K, `SPAN_128K, `SPAN_128K, `SPAN_128K,
    `SPAN_128K, `SPAN_128K, `SPAN_128K, `SPAN_128K, `SPAN_64K};

  localparam logic [31:0] LIMIT [N] = '{
    `SPAN_4M, `SPAN_32K, `SPAN_32K, `SPAN_16M, `SPAN_16M, `SPAN_16M,
    `SPAN_128M, `SPAN_512K, `SPAN_2K, `SPAN_8K, `CRC_LIMIT, `CRC_LIMIT,
    `SPAN_2K, `SPAN_2K, `SPAN_2K, `SPAN_2K, `SPAN_4K,
    `SPAN_8K, `SPAN_8K, `SPAN_8K, `SPAN_8K,
    `SPAN_16K, `SPAN_16K, `SPAN_16K, `SPAN_16K, `SPAN_64K};

  // Only the Ethernet slave frame forgives a miss; all others abort
  localparam sys_decode_pkg::miss_t MISS [N] = '{
    default: sys_decode_pkg::MISS_ABORT,
    `T_ETH_SLV: sys_decode_pkg::MISS_NOERR};

  logic [N-1:0] hit;
  logic [N-1:0] lim;
  logic [31:0]  off_w [N];

  for (genvar i = 0; i < N; i++) begin : g_frame
    frame_match #(
      .BASE  (BASE[i]),
      .SPAN  (SPAN[i]),
      .LIMIT (LIMIT[i])
    ) u_frame (
      .addr     (req_addr),
      .hit      (hit[i]),
      .in_limit (lim[i]),
      .off      (off_w[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  sys_decode_pkg::action_t act;
  logic [N-1:0]            route_sel;
  logic [31:0]             raw_off;
  logic [31:0]             lut_off;
  logic                    dbg_slot_ok;

  lut_fold u_lut_fold (
    .off    (raw_off),
    .folded (lut_off)
  );

  localparam logic [15:0] DBG_MAP = `DBG_SLOTS;
  assign dbg_slot_ok = DBG_MAP[req_addr[`DBG_SLOT_MSB:`DBG_SLOT_LSB]];

  always_comb begin
    act       = sys_decode_pkg::ACT_ABORT;
    route_sel = '0;
    raw_off   = '0;
    for (int i = 0; i < N; i++) begin
      if (hit[i]) begin
        raw_off = off_w[i];
        if (lim[i]) begin
          act          = sys_decode_pkg::ACT_ROUTE;
          route_sel[i] = 1'b1;
        end else begin
          case (MISS[i])
            sys_decode_pkg::MISS_NOERR: act = sys_decode_pkg::ACT_NOERR;
            sys_decode_pkg::MISS_RAZWI: act = sys_decode_pkg::ACT_RAZWI;
            default: act = sys_decode_pkg::ACT_ABORT;
          endcase
        end
      end
    end
    // Empty debug slots answer quietly rather than fault
    if (hit[`T_DBG] && !dbg_slot_ok) begin
      act       = sys_decode_pkg::ACT_RAZWI;
      route_sel = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer

  dec_state_t q;
  dec_state_t d;
  logic       use_lut;

  assign use_lut = hit[`T_CONV1] || hit[`T_CONV2];

  always_comb begin
    d       = q;
    d.done  = 1'b0;
    d.abort = 1'b0;
    d.raz   = 1'b0;
    case (q.st)
      sys_decode_pkg::ST_IDLE: begin
        if (req_valid) begin
          d.offset = use_lut ? lut_off : raw_off;
          d.write  = req_write;
          if (act == sys_decode_pkg::ACT_ROUTE) begin
            d.sel = route_sel;
            d.st  = sys_decode_pkg::ST_ROUTE;
          end else begin
            // Error responder answers on its own, one cycle later
            d.done  = 1'b1;
            d.abort = act == sys_decode_pkg::ACT_ABORT;
            d.raz   = act == sys_decode_pkg::ACT_RAZWI && !req_write;
            d.st    = sys_decode_pkg::ST_HOLD;
          end
        end
      end
      sys_decode_pkg::ST_ROUTE: begin
        // Address is latched, so a master that drifts cannot retarget
        if (tgt_done) begin
          d.sel   = '0;
          d.done  = 1'b1;
          d.abort = tgt_error;
          d.st    = sys_decode_pkg::ST_HOLD;
        end
      end
      sys_decode_pkg::ST_HOLD: begin
        // Skips the cycle in which the master still shows the old request
        d.st = sys_decode_pkg::ST_IDLE;
      end
      default: begin
        d.st = sys_decode_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '{st: sys_decode_pkg::ST_IDLE, sel: '0, offset: '0, write: 1'b0,
             done: 1'b0, abort: 1'b0, raz: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign tgt_sel    = q.sel;
  assign tgt_offset = q.offset;
  assign tgt_write  = q.write;
  assign xfer_done  = q.done;
  assign xfer_abort = q.abort;
  assign xfer_raz   = q.raz;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  logic taken;
  assign taken = q.st == sys_decode_pkg::ST_IDLE && req_valid;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_flash_route: assert property (taken && (req_addr - `FLASH_BASE) <= `SPAN_4M
    |=> tgt_sel[`T_FLASH] && !xfer_done) else $error("flash access not routed");
  a_dcache_abort: assert property (taken && (req_addr - `DCACHE_BASE) <= `SPAN_16M
    && (req_addr - `DCACHE_BASE) > `SPAN_32K |=> xfer_done && xfer_abort && tgt_sel == '0)
    else $error("data cache hole not aborted");
  a_icache_route: assert property (taken && (req_addr - `ICACHE_BASE) <= `SPAN_32K
    |=> tgt_sel[`T_ICACHE]) else $error("instruction cache not routed");
  a_async_route: assert property (taken && (req_addr - `CS3_BASE) <= `SPAN_16M
    |=> tgt_sel[`T_CS3] && tgt_offset == $past(req_addr) - `CS3_BASE)
    else $error("async window not routed");
  a_sync_route: assert property (taken && (req_addr - `CS0_BASE) <= `SPAN_128M
    |=> tgt_sel[`T_CS0]) else $error("sync window not routed");
  a_ext_reserved: assert property (taken && (req_addr - `CS2_BASE) <= `SPAN_64M
    && (req_addr - `CS2_BASE) > `SPAN_16M |=> xfer_done && xfer_abort)
    else $error("external reserved space not aborted");
  a_fecc_route: assert property (taken && (req_addr - `FECC_BASE) <= `SPAN_512K
    |=> tgt_sel[`T_FECC]) else $error("flash ECC not routed");
  a_eth_noerr: assert property (taken && (req_addr - `ETH_SLV_BASE) <= `SPAN_2K
    |=> !xfer_abort) else $error("ethernet slave access errored");
  a_crc1_abort: assert property (taken && (req_addr - `CRC1_BASE) <= `SPAN_16M
    && (req_addr - `CRC1_BASE) > `CRC_LIMIT |=> xfer_done && xfer_abort)
    else $error("first checksum frame not aborted");
  a_crc2_split: assert property (taken && (req_addr - `CRC2_BASE) <= `CRC_LIMIT
    |=> tgt_sel[`T_CRC2] ##1 !xfer_abort [*1]) else $error("second checksum low not routed");
  a_sb_abort: assert property (taken && (req_addr - `SB5_BASE) <= `SPAN_128K
    && (req_addr - `SB5_BASE) > `SPAN_2K |=> xfer_done && xfer_abort)
    else $error("small serial buffer not aborted");
  a_sb1_route: assert property (taken && (req_addr - `SB1_BASE) <= `SPAN_4K
    |=> tgt_sel[`T_SB1]) else $error("large serial buffer not routed");
  a_can_abort: assert property (taken && (req_addr - `CAN1_BASE) <= `SPAN_128K
    && (req_addr - `CAN1_BASE) > `SPAN_8K |=> xfer_done && xfer_abort)
    else $error("message memory not aborted");
  a_conv_result: assert property (taken && (req_addr - `CONV1_BASE) <= `SPAN_8K
    |=> tgt_sel[`T_CONV1] && tgt_offset == ($past(req_addr) & `SPAN_8K))
    else $error("converter result offset wrong");
  a_lut_direct: assert property (taken && (req_addr - `CONV2_BASE) >= `LUT_START
    && (req_addr - `CONV2_BASE) < `LUT_START + `LUT_BYTES
    |=> tgt_offset == $past(req_addr) - `CONV2_BASE) else $error("lookup table offset moved");
  a_lut_wrap: assert property (taken && (req_addr - `CONV2_BASE) >= `LUT_START
    && (req_addr - `CONV2_BASE) <= `SPAN_16K |=> tgt_sel[`T_CONV2]
    && tgt_offset >= `LUT_START && tgt_offset < `LUT_START + `LUT_BYTES)
    else $error("lookup wrap out of table");
  a_conv_abort: assert property (taken && (req_addr - `CONV1_BASE) <= `SPAN_128K
    && (req_addr - `CONV1_BASE) > `SPAN_16K |=> xfer_done && xfer_abort)
    else $error("converter beyond region not aborted");
  a_tmr_abort: assert property (taken && (req_addr - `TMR1_BASE) <= `SPAN_128K
    && (req_addr - `TMR1_BASE) > `SPAN_16K |=> xfer_done && xfer_abort ##1 !xfer_done)
    else $error("timer memory beyond not aborted");
  a_dbg_raz: assert property (taken && !req_write && (req_addr - `DBG_BASE) <= `SPAN_64K
    && !dbg_slot_ok |=> xfer_done && xfer_raz && !xfer_abort && tgt_sel == '0)
    else $error("empty debug slot not read as zero");
  a_ethd_route: assert property (taken && (req_addr - `ETH_DESC_BASE) <= `SPAN_8K
    |=> tgt_sel[`T_ETH_DESC]) else $error("descriptor memory not routed");
  a_one_select: assert property ($onehot0(tgt_sel) && !(xfer_done && tgt_sel != '0))
    else $error("more than one target selected");
  a_route_end: assert property (q.st == sys_decode_pkg::ST_ROUTE && tgt_done
    |=> xfer_done && tgt_sel == '0 ##1 !xfer_done) else $error("routed transfer not ended");

  ////////////////////////////////////////////////////////////////////////////////
  // Frame edges not covered above, then write flag, target error and select hold checks

  a_cs2_route: assert property (taken && (req_addr - `CS2_BASE) <= `SPAN_16M
    |=> tgt_sel[`T_CS2] && tgt_offset == $past(req_addr) - `CS2_BASE)
    else $error("first async window not routed");
  a_cs4_reserved: assert property (taken && (req_addr - `CS4_BASE) <= `SPAN_64M
    && (req_addr - `CS4_BASE) > `SPAN_16M |=> xfer_done && xfer_abort && tgt_sel == '0)
    else $error("third async reserved space not aborted");
  a_icache_abort: assert property (taken && (req_addr - `ICACHE_BASE) <= `SPAN_16M
    && (req_addr - `ICACHE_BASE) > `SPAN_32K |=> xfer_done && xfer_abort)
    else $error("instruction cache hole not aborted");
  a_fecc_abort: assert property (taken && (req_addr - `FECC_BASE) <= `SPAN_2M
    && (req_addr - `FECC_BASE) > `SPAN_512K |=> xfer_done && xfer_abort)
    else $error("flash ECC hole not aborted");
  a_crc1_route: assert property (taken && (req_addr - `CRC1_BASE) <= `CRC_LIMIT
    |=> tgt_sel[`T_CRC1] && tgt_offset == $past(req_addr) - `CRC1_BASE)
    else $error("first checksum low not routed");
  a_crc2_abort: assert property (taken && (req_addr - `CRC2_BASE) <= `SPAN_16M
    && (req_addr - `CRC2_BASE) > `CRC_LIMIT |=> xfer_done && xfer_abort)
    else $error("second checksum frame not aborted");
  a_sb_route: assert property (taken && (req_addr - `SB5_BASE) <= `SPAN_2K
    |=> tgt_sel[`T_SB5] && tgt_offset == $past(req_addr) - `SB5_BASE)
    else $error("small serial buffer not routed");
  a_sb1_abort: assert property (taken && (req_addr - `SB1_BASE) <= `SPAN_128K
    && (req_addr - `SB1_BASE) > `SPAN_4K |=> xfer_done && xfer_abort)
    else $error("large serial buffer not aborted");
  a_can_route: assert property (taken && (req_addr - `CAN1_BASE) <= `SPAN_8K
    |=> tgt_sel[`T_CAN1] && tgt_offset == $past(req_addr) - `CAN1_BASE)
    else $error("message memory not routed");
  a_conv2_result: assert property (taken && (req_addr - `CONV2_BASE) <= `SPAN_8K
    |=> tgt_sel[`T_CONV2] && tgt_offset == ($past(req_addr) & `SPAN_8K))
    else $error("second converter result offset wrong");
  a_tmr_route: assert property (taken && (req_addr - `TMR2_BASE) <= `SPAN_16K
    |=> tgt_sel[`T_TMR2] && tgt_offset == $past(req_addr) - `TMR2_BASE)
    else $error("timer memory not routed");
  a_dbg_quiet: assert property (taken && req_write && !dbg_slot_ok
    && (req_addr - `DBG_BASE) <= `SPAN_64K |=> xfer_done && !xfer_raz && !xfer_abort
    && tgt_sel == '0) else $error("empty debug slot write not ignored");
  a_unmapped_abort: assert property (taken && req_addr > `SPAN_4M
    && req_addr < `DCACHE_BASE |=> xfer_done && xfer_abort && tgt_sel == '0)
    else $error("unmapped address not aborted");
  a_write_copy: assert property (taken |=> tgt_write == $past(req_write))
    else $error("write flag not carried");
  a_err_abort: assert property (q.st == sys_decode_pkg::ST_ROUTE && tgt_done
    |=> xfer_abort == $past(tgt_error)) else $error("target error not returned");
  a_sel_hold: assert property (q.st == sys_decode_pkg::ST_ROUTE && !tgt_done
    |=> $stable(tgt_sel) && $stable(tgt_offset) && !xfer_done)
    else $error("routed select moved while waiting");

  c_routed: cover property (taken ##1 tgt_sel != '0 ##[1:8] xfer_done && !xfer_abort);
  c_abort:  cover property (taken ##1 xfer_done && xfer_abort);
  c_raz:    cover property (taken ##1 xfer_done && xfer_raz);
  c_wrap:   cover property (taken && use_lut && lut_off != raw_off);
  c_tgterr: cover property (q.st == sys_decode_pkg::ST_ROUTE && tgt_done && tgt_error);

endmodule : system_address_decoder
`default_nettype wire

/* logic/sys_decode_regs.svh */
`ifndef SYS_DECODE_REGS_SVH
`define SYS_DECODE_REGS_SVH

// Frame spans as size minus one, then the checksum limit and lookup table constants
`define SPAN_2K          32'h0000_07ff
`define SPAN_4K          32'h0000_0fff
`define SPAN_8K          32'h0000_1fff
`define SPAN_16K         32'h0000_3fff
`define SPAN_32K         32'h0000_7fff
`define SPAN_64K         32'h0000_ffff
`define SPAN_128K        32'h0001_ffff
`define SPAN_512K        32'h0007_ffff
`define SPAN_2M          32'h001f_ffff
`define SPAN_4M          32'h003f_ffff
`define SPAN_16M         32'h00ff_ffff
`define SPAN_64M         32'h03ff_ffff
`define SPAN_128M        32'h07ff_ffff
`define CRC_LIMIT        32'h0000_0200
`define LUT_START        32'h0000_2000
`define LUT_BYTES        32'h0000_0180

// Frame bases
`define FLASH_BASE       32'h0000_0000
`define DCACHE_BASE      32'h3000_0000
`define ICACHE_BASE      32'h3100_0000
`define CS2_BASE         32'h6000_0000
`define CS3_BASE         32'h6400_0000
`define CS4_BASE         32'h6800_0000
`define CS0_BASE         32'h8000_0000
`define FECC_BASE        32'hf040_0000
`define ETH_SLV_BASE     32'hfcf7_8000
`define ETH_DESC_BASE    32'hfc52_0000
`define CRC1_BASE        32'hfe00_0000
`define CRC2_BASE        32'hfb00_0000
`define SB5_BASE         32'hff0a_0000
`define SB4_BASE         32'hff06_0000
`define SB3_BASE         32'hff0c_0000
`define SB2_BASE         32'hff08_0000
`define SB1_BASE         32'hff0e_0000
`define CAN4_BASE        32'hff18_0000
`define CAN3_BASE        32'hff1a_0000
`define CAN2_BASE        32'hff1c_0000
`define CAN1_BASE        32'hff1e_0000
`define CONV2_BASE       32'hff3a_0000
`define CONV1_BASE       32'hff3e_0000
`define TMR2_BASE        32'hff44_0000
`define TMR1_BASE        32'hff46_0000
`define DBG_BASE         32'hffa0_0000

// Debug slots present, one bit per 4kB slot
`define DBG_SLOTS        16'h0e9f
`define DBG_SLOT_MSB     15
`define DBG_SLOT_LSB     12

// Target indices on the select vector
`define TARGET_COUNT     26
`define T_FLASH          0
`define T_DCACHE         1
`define T_ICACHE         2
`define T_CS2            3
`define T_CS3            4
`define T_CS4            5
`define T_CS0            6
`define T_FECC           7
`define T_ETH_SLV        8
`define T_ETH_DESC       9
`define T_CRC1           10
`define T_CRC2           11
`define T_SB5            12
`define T_SB1            16
`define T_CAN1           20
`define T_CONV2          21
`define T_CONV1          22
`define T_TMR2           23
`define T_TMR1           24
`define T_DBG            25

`endif

/* logic/sys_decode_pkg.sv */
package sys_decode_pkg;

  typedef enum logic [1:0] {
    MISS_ABORT = 2'h0,
    MISS_NOERR = 2'h1,
    MISS_RAZWI = 2'h2
  } miss_t;

  typedef enum logic [1:0] {
    ACT_ROUTE = 2'h0,
    ACT_ABORT = 2'h1,
    ACT_NOERR = 2'h2,
    ACT_RAZWI = 2'h3
  } action_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ROUTE = 2'h1,
    ST_HOLD  = 2'h3
  } state_t;

endpackage : sys_decode_pkg

/* logic/frame_match.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sys_decode_regs.svh"

module frame_match #(
  parameter logic [31:0] BASE  = 32'h0000_0000,
  parameter logic [31:0] SPAN  = 32'h0000_0fff,
  parameter logic [31:0] LIMIT = 32'h0000_0fff
) (
  input  wire logic [31:0] addr,
  output logic             hit,
  output logic             in_limit,
  output logic [31:0]      off
);

  // Frames are aligned to their span, so a mask compare suffices
  assign hit      = (addr & ~SPAN) == BASE;
  assign off      = addr & SPAN;
  assign in_limit = off <= LIMIT;

endmodule : frame_match
`default_nettype wire

/* logic/lut_fold.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sys_decode_regs.svh"

module lut_fold (
  input  wire logic [31:0] off,
  output logic [31:0]      folded
);

  logic        in_lut;
  logic [31:0] rel;

  assign rel    = off - `LUT_START;
  assign in_lut = (off >= `LUT_START) && (off <= `SPAN_16K);
  // Table is 384 bytes, not a power of two, hence a true modulo
  assign folded = in_lut ? `LUT_START + (rel % `LUT_BYTES)
                         : off & `SPAN_8K;

endmodule : lut_fold
`default_nettype wire

/* tb/tgt_responder.sv */
`timescale 1ns/10ps
`default_nettype none

module tgt_responder (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [25:0] tgt_sel,
  input  wire logic [3:0]  delay,
  input  wire logic        fail,
  output logic             tgt_done,
  output logic             tgt_error
);
  logic [3:0] cnt_q;
  logic       busy_q;
  logic       junk_q;

  ////////////////////////////////////////////////////////////////////////////////
  // One done pulse per select, delay+1 cycles after the select appears
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q    <= 4'h0;
      busy_q   <= 1'h0;
      junk_q   <= 1'h0;
      tgt_done <= 1'h0;
    end else begin
      junk_q   <= ~junk_q;
      tgt_done <= 1'h0;
      if (tgt_sel == 26'h0) begin
        busy_q <= 1'h0;
        cnt_q  <= 4'h0;
      end else if (!busy_q) begin
        if (cnt_q == delay) begin
          tgt_done <= 1'h1;
          busy_q   <= 1'h1;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end

  // Error line is junk outside done, so a stray sample cannot pass
  assign tgt_error = tgt_done ? fail : junk_q;

endmodule : tgt_responder
`default_nettype wire

/* tb/system_address_decoder_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sys_decode_regs.svh"

module system_address_decoder_tb;
  logic        core_clk;
  logic        rst;
  logic        req_valid;
  logic [31:0] req_addr;
  logic        req_write;
  logic        tgt_done;
  logic        tgt_error;
  logic [25:0] tgt_sel;
  logic [31:0] tgt_offset;
  logic        tgt_write;
  logic        xfer_done;
  logic        xfer_abort;
  logic        xfer_raz;
  logic [3:0]  delay;
  logic        fail;
  int          bad_count;
  int          n_tests;

  system_address_decoder u_system_address_decoder (
    .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_addr(req_addr),
    .req_write(req_write), .tgt_done(tgt_done), .tgt_error(tgt_error),
    .tgt_sel(tgt_sel), .tgt_offset(tgt_offset), .tgt_write(tgt_write),
    .xfer_done(xfer_done), .xfer_abort(xfer_abort), .xfer_raz(xfer_raz));

  tgt_responder u_tgt_responder (
    .core_clk(core_clk), .rst(rst), .tgt_sel(tgt_sel), .delay(delay),
    .fail(fail), .tgt_done(tgt_done), .tgt_error(tgt_error));

  always #2 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One access; rsp is {abort, read_zero}; idx -1 means no select
  task automatic xf(input logic [31:0] a, input logic w, input int idx,
                    input logic [31:0] off, input logic [1:0] rsp);
    logic [25:0] sel_seen;
    logic [31:0] off_seen;
    bit          got;
    sel_seen = 26'h0;
    off_seen = 32'h0;
    got = 0;
    @(negedge core_clk);
    chk({31'h0, xfer_done}, 32'h0);
    req_valid = 1'h1;
    req_addr  = a;
    req_write = w;
    // Request held until done shows
    for (int i = 0; i < 40 && !got; i++) begin
      @(negedge core_clk);
      if (tgt_sel !== 26'h0 && sel_seen === 26'h0) begin
        sel_seen = tgt_sel;
        off_seen = tgt_offset;
      end
      if (xfer_done === 1'h1) got = 1;
    end
    req_valid = 1'h0;
    if (!got) begin
      bad_count++;
      wrap_up();
    end
    chk({6'h0, sel_seen}, (idx < 0) ? 32'h0 : (32'h1 << idx));
    chk({6'h0, tgt_sel}, 32'h0);
    chk({30'h0, xfer_abort, xfer_raz}, {30'h0, rsp});
    if (idx >= 0) begin
      chk(off_seen, off);
      chk({31'h0, tgt_write}, {31'h0, w});
    end
  endtask : xf

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_core_mem();
    xf(32'h003f_fffc, 1'h0, 0, 32'h003f_fffc, 2'h0);
    xf(32'h0040_0000, 1'h0, -1, 32'h0, 2'h2);
    xf(32'h3000_7ffc, 1'h1, 1, 32'h0000_7ffc, 2'h0);
    xf(32'h3000_8000, 1'h0, -1, 32'h0, 2'h2);
    xf(32'h3100_0010, 1'h0, 2, 32'h0000_0010, 2'h0);
    xf(32'h3100_8000, 1'h1, -1, 32'h0, 2'h2);
  endtask : t_core_mem

  task automatic t_ext_mem();
    xf(32'h60ff_fff0, 1'h0, 3, 32'h00ff_fff0, 2'h0);
    xf(32'h6100_0000, 1'h0, -1, 32'h0, 2'h2);
    xf(32'h6400_0000, 1'h1, 4, 32'h0, 2'h0);
    xf(32'h6bff_fffc, 1'h0, -1, 32'h0, 2'h2);
    xf(32'h6800_0004, 1'h0, 5, 32'h0000_0004, 2'h0);
    xf(32'h87ff_fffc, 1'h1, 6, 32'h07ff_fffc, 2'h0);
    xf(32'h8800_0000, 1'h0, -1, 32'h0, 2'h2);
  endtask : t_ext_mem

  task automatic t_periph();
    xf(32'hf047_fffc, 1'h0, 7, 32'h0007_fffc, 2'h0);
    xf(32'hf048_0000, 1'h0, -1, 32'h0, 2'h2);
    xf(32'hfcf7_87fc, 1'h1, 8, 32'h0000_07fc, 2'h0);
    xf(32'hfc52_1ffc, 1'h0, 9, 32'h0000_1ffc, 2'h0);
    xf(32'hfe00_0200, 1'h0, 10, 32'h0000_0200, 2'h0);
    xf(32'hfe00_0204, 1'h1, -1, 32'h0, 2'h2);
    xf(32'hfb00_0200, 1'h1, 11, 32'h0000_0200, 2'h0);
    xf(32'hfb00_0204, 1'h0, -1, 32'h0, 2'h2);
  endtask : t_periph

  task automatic t_buffers();
    logic [31:0] sb [4];
    logic [31:0] cb;
    sb = '{`SB5_BASE, `SB4_BASE, `SB3_BASE, `SB2_BASE};
    for (int i = 0; i < 4; i++) begin
      cb = `CAN4_BASE + 32'h0002_0000 * i;
      xf(sb[i] + 32'h7fc, 1'h0, 12 + i, 32'h0000_07fc, 2'h0);
      xf(sb[i] + 32'h800, 1'h1, -1, 32'h0, 2'h2);
      xf(cb + 32'h1ffc, 1'h1, 17 + i, 32'h0000_1ffc, 2'h0);
      xf(cb + 32'h2000, 1'h0, -1, 32'h0, 2'h2);
    end
    xf(32'hff0e_0ffc, 1'h1, 16, 32'h0000_0ffc, 2'h0);
    xf(32'hff0e_1000, 1'h0, -1, 32'h0, 2'h2);
  endtask : t_buffers

  task automatic t_converter();
    xf(32'hff3a_1ffc, 1'h0, 21, 32'h0000_1ffc, 2'h0);
    xf(32'hff3a_2190, 1'h1, 21, 32'h0000_2010, 2'h0);
    xf(32'hff3e_3ffc, 1'h0, 22, 32'h0000_207c, 2'h0);
    xf(32'hff3e_217c, 1'h0, 22, 32'h0000_217c, 2'h0);
    xf(32'hff3e_4000, 1'h1, -1, 32'h0, 2'h2);
    xf(32'hff44_3ffc, 1'h1, 23, 32'h0000_3ffc, 2'h0);
    xf(32'hff46_4000, 1'h0, -1, 32'h0, 2'h2);
  endtask : t_converter

  task automatic t_debug();
    xf(32'hffa0_0000, 1'h0, 25, 32'h0, 2'h0);
    xf(32'hffa0_b004, 1'h1, 25, 32'h0000_b004, 2'h0);
    xf(32'hffa0_5000, 1'h0, -1, 32'h0, 2'h1);
    xf(32'hffa0_5000, 1'h1, -1, 32'h0, 2'h0);
    xf(32'hffa0_8010, 1'h0, -1, 32'h0, 2'h1);
    xf(32'hffa1_0000, 1'h0, -1, 32'h0, 2'h2);
  endtask : t_debug

  // Slow target and target error; error must come back as abort
  task automatic t_slow_err();
    delay = 4'h9;
    fail  = 1'h1;
    xf(32'h0000_0100, 1'h1, 0, 32'h0000_0100, 2'h2);
    fail  = 1'h0;
    xf(32'h8000_0020, 1'h0, 6, 32'h0000_0020, 2'h0);
    delay = 4'h0;
  endtask : t_slow_err

  task automatic t_reset_mid();
    delay = 4'h8;
    @(negedge core_clk);
    req_valid = 1'h1;
    req_addr  = 32'h3000_0040;
    req_write = 1'h1;
    repeat (3) @(negedge core_clk);
    chk({6'h0, tgt_sel}, 32'h0000_0002);
    rst       = 1'h1;
    req_valid = 1'h0;
    repeat (2) @(negedge core_clk);
    chk({2'h0, tgt_sel, xfer_done, xfer_abort, xfer_raz, tgt_write}, 32'h0);
    chk(tgt_offset, 32'h0);
    rst   = 1'h0;
    delay = 4'h1;
    xf(32'h3000_0040, 1'h0, 1, 32'h0000_0040, 2'h0);
  endtask : t_reset_mid

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk  = 1'h0;
    rst       = 1'h1;
    req_valid = 1'h0;
    req_addr  = 32'h0;
    req_write = 1'h0;
    delay     = 4'h0;
    fail      = 1'h0;
    bad_count = 0;
    n_tests   = 0;
    repeat (2) @(negedge core_clk);
    rst = 1'h0;
    t_core_mem();
    t_ext_mem();
    t_periph();
    t_buffers();
    t_converter();
    t_debug();
    t_slow_err();
    t_reset_mid();
    wrap_up();
  end

endmodule : system_address_decoder_tb
`default_nettype wire
